// File: sib_pkg.sv
// sib_pkg: constants and carrier types for the serial irq/buffer/reset block
// assumes: one 20 MHz clock domain; no register bus, all control bits are ports
package sib_pkg;
  localparam int unsigned SIB_CLK_HZ = 20000000;
  localparam int unsigned SIB_BITS = 8;
  localparam logic [3:0] SIB_BIT_LAST = 4'h8;
  localparam logic [3:0] SIB_CAP_BIT1 = 4'h7;   // capture of bit 1 (msb first, 7 done)
  localparam logic [7:0] SIB_SHIFT_RST = 8'h00;
  localparam logic [3:0] SIB_CNT_RST = 4'h0;
  // master clock divide per half serial bit, indexed by {baud_select_hi, baud_select_lo}
  localparam logic [6:0] SIB_HALF_DIV2 = 7'h01;
  localparam logic [6:0] SIB_HALF_DIV8 = 7'h04;
  localparam logic [6:0] SIB_HALF_DIV32 = 7'h10;
  localparam logic [6:0] SIB_HALF_DIV128 = 7'h40;

  typedef struct packed {
    logic module_on;
    logic master_select;
    logic cpol;
    logic cpha;
    logic wired_or_select;
    logic tx_empty_irq_en;
    logic rx_full_irq_en;
    logic error_irq_en;
    logic fault_detect_en;
    logic baud_select_hi;
    logic baud_select_lo;
  } sib_ctrl_t;

  typedef struct packed {
    logic tx_empty_flag;
    logic rx_full_flag;
    logic overrun_flag;
    logic mode_fault_flag;
  } sib_stat_t;

  typedef struct packed {
    logic o;
    logic oe;
  } sib_pin_t;

  typedef enum logic [2:0] {
    SIB_IDLE = 3'b001,
    SIB_LEAD = 3'b010,
    SIB_TRAIL = 3'b100
  } sib_state_t;
endpackage : sib_pkg

// File: sib_core.sv
// sib_core: serial byte engine with interrupt requests, two-entry transmit buffer,
// partial reset, stop/break handling and pin direction ownership
// assumes: cpu strobes are single-cycle and synchronous to clk; pins are asynchronous
//
// Notes on behaviour
// - tx irq when empty flag and enable
// - rx irq needs enable and module on
// - error enable gates overrun and mode fault
// - no mode fault without fault detect
// - rx full set on byte to receive register
// - tx empty set on byte to shifter
// - master queued byte starts without gap
// - slave resends shifter when nothing queued
// - system reset clears everything but master_select, cpha and tx empty, which it sets
// - module off aborts, clears shifter, counter
// - control bits and rx flags survive module off
// - master mode fault turns module off
// - runs in wait; irqs wake cpu
// - stop freezes; reset exit aborts
// - break without clear enable freezes flag clears
// - data write in break without clear enable ignored
// - miso driven only by selected slave
// - enabled module owns pin directions
// - clock out as master, in as slave; 8 bits
// - master shifts out and samples together
// - wired-or makes mosi open drain
// - unread data at bit 1 sets overrun
// - master low select sets mode fault
// - data read clears rx full
`timescale 1ns/1ps
module sib_core
  import sib_pkg::*;
(
  input wire logic clk,                 // 20 MHz bus clock
  input wire logic rst,                 // synchronous system reset
  input wire sib_ctrl_t ctrl_wr,        // control bits to load
  input wire logic ctrl_we,             // load ctrl_wr (pulse)
  input wire logic [7:0] data_wr,       // byte written to data register
  input wire logic data_we,             // data register write (pulse)
  input wire logic data_re,             // data register read (pulse)
  input wire logic stat_re,             // status register read (pulse)
  input wire logic stop_mode,           // processor in stop
  input wire logic break_state,         // processor in break
  input wire logic break_clear_en,      // flags clearable in break
  input wire logic sck_in,              // serial clock pin level
  input wire logic mosi_in,             // mosi pin level
  input wire logic miso_in,             // miso pin level
  input wire logic ss_n_in,             // slave select pin, active low
  output sib_ctrl_t ctrl,               // control bits held
  output sib_stat_t stat,               // status flags
  output logic [7:0] rx_data,           // receive data register
  output logic tx_irq,                  // transmitter request level
  output logic rx_err_irq,              // receiver/error request level
  output sib_pin_t sck_pin,             // serial clock drive
  output sib_pin_t mosi_pin,            // mosi drive
  output sib_pin_t miso_pin,            // miso drive
  output logic pins_owned               // 1: port ddr overridden
);
  function automatic logic [6:0] half_div(input logic hi, input logic lo);
    unique case ({hi, lo})
      2'b00: half_div = SIB_HALF_DIV2;
      2'b01: half_div = SIB_HALF_DIV8;
      2'b10: half_div = SIB_HALF_DIV32;
      default: half_div = SIB_HALF_DIV128;
    endcase
  endfunction : half_div

  // two-flop synchronisers; only stage two is read
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic sck_prev;
  always_ff @(posedge clk) begin
    sync1 <= {sck_in, mosi_in, miso_in, ss_n_in};
    sync2 <= sync1;
    sck_prev <= sync2[3];
  end
  logic sck_s, mosi_s, miso_s, ss_n_s;
  assign {sck_s, mosi_s, miso_s, ss_n_s} = sync2;

  // two-entry transmit buffer, valid/ready both sides
  logic [7:0] buf_mem [2];
  logic [1:0] buf_cnt;
  logic buf_wp, buf_rp;
  logic buf_in_ready, buf_out_valid, buf_pop;
  assign buf_in_ready = (buf_cnt != 2'h2);
  assign buf_out_valid = (buf_cnt != 2'h0);

  sib_state_t state;
  logic [7:0] shifter;
  logic [3:0] bit_cnt;
  logic [6:0] div_cnt;
  logic sck_int;
  logic sample_bit;
  logic active;
  logic slave_sel;
  logic run;
  logic freeze;
  logic mf_cond;
  logic push;
  logic sck_lead, sck_trail;
  logic byte_done;
  logic cap_bit1;

  assign active = ctrl.module_on && !stop_mode;
  assign freeze = break_state && !break_clear_en;
  assign slave_sel = !ctrl.master_select && !ss_n_s;
  assign mf_cond = ctrl.module_on && ctrl.fault_detect_en && ctrl.master_select && !ss_n_s;
  assign push = data_we && !freeze && buf_in_ready;
  assign run = (state != SIB_IDLE);

  // edge finding: master uses its own divider, slave the sampled pin
  always_comb begin
    if (ctrl.master_select) begin
      sck_lead = run && (div_cnt == 7'h00) && (state == SIB_LEAD);
      sck_trail = run && (div_cnt == 7'h00) && (state == SIB_TRAIL);
    end else begin
      sck_lead = slave_sel && (sck_s ^ ctrl.cpol) && !(sck_prev ^ ctrl.cpol);
      sck_trail = slave_sel && !(sck_s ^ ctrl.cpol) && (sck_prev ^ ctrl.cpol);
    end
  end
  // cpha 0 samples on leading edge, cpha 1 on trailing
  logic samp_edge, shift_edge;
  assign samp_edge = ctrl.cpha ? sck_trail : sck_lead;
  assign shift_edge = ctrl.cpha ? sck_lead : sck_trail;
  assign byte_done = samp_edge && (bit_cnt == SIB_BIT_LAST - 4'h1);
  assign cap_bit1 = samp_edge && (bit_cnt == SIB_CAP_BIT1 - 4'h1);

  // load shifter from buffer: master on write or back to back, slave at start
  always_comb begin
    buf_pop = 1'b0;
    if (active && buf_out_valid && !freeze) begin
      if (ctrl.master_select)
        buf_pop = (state == SIB_IDLE) || byte_done;
      else
        buf_pop = (state == SIB_IDLE) && !run;
    end
  end

  // buffer storage
  always_ff @(posedge clk) begin
    if (rst || !ctrl.module_on) begin
      buf_cnt <= 2'h0;
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
    end else begin
      if (push) begin
        buf_mem[buf_wp] <= data_wr;
        buf_wp <= !buf_wp;
      end
      if (buf_pop)
        buf_rp <= !buf_rp;
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, buf_pop};
    end
  end

  // transfer state, divider, counter and shifter
  always_ff @(posedge clk) begin
    if (rst || !ctrl.module_on) begin
      state <= SIB_IDLE;
      shifter <= SIB_SHIFT_RST;
      bit_cnt <= SIB_CNT_RST;
      div_cnt <= 7'h00;
      sck_int <= 1'b0;
      sample_bit <= 1'b0;
    end else if (active) begin
      if (ctrl.master_select) begin
        if (run)
          div_cnt <= (div_cnt == 7'h00) ? half_div(ctrl.baud_select_hi, ctrl.baud_select_lo)
                     - 7'h01 : div_cnt - 7'h01;
        if (state == SIB_IDLE && buf_pop) begin
          state <= SIB_LEAD;
          div_cnt <= half_div(ctrl.baud_select_hi, ctrl.baud_select_lo) - 7'h01;
        end else if (sck_lead) begin
          state <= SIB_TRAIL;
          sck_int <= 1'b1;
        end else if (sck_trail) begin
          sck_int <= 1'b0;
          state <= (byte_done && !buf_pop) ? SIB_IDLE : SIB_LEAD;
        end
      end else if (!slave_sel) begin
        state <= SIB_IDLE;  // deselected slave ignores clocks
      end else if (sck_lead || sck_trail) begin
        state <= SIB_LEAD;
      end
      if (buf_pop)
        shifter <= buf_mem[buf_rp];
      else if (samp_edge)
        sample_bit <= ctrl.master_select ? miso_s : mosi_s;
      if (shift_edge && !buf_pop && bit_cnt != SIB_CNT_RST)
        shifter <= {shifter[6:0], sample_bit};
      if (byte_done) begin
        bit_cnt <= SIB_CNT_RST;
        if (!ctrl.master_select)
          state <= SIB_IDLE;
      end else if (samp_edge) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // control bits: only system reset clears them; a master fault drops module_on
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= '0;
      ctrl.master_select <= 1'b1;
      ctrl.cpha <= 1'b1;
    end else begin
      if (ctrl_we)
        ctrl <= ctrl_wr;
      if (mf_cond)
        ctrl.module_on <= 1'b0;
    end
  end

  // status flags; sets win over clears, break freezes clears
  logic rf_armed, mf_armed;
  logic last_byte;
  always_ff @(posedge clk) begin
    if (rst) begin
      stat.rx_full_flag <= 1'b0;
      stat.overrun_flag <= 1'b0;
      stat.mode_fault_flag <= 1'b0;
      stat.tx_empty_flag <= 1'b1;
      rx_data <= 8'h00;
      rf_armed <= 1'b0;
      mf_armed <= 1'b0;
    end else begin
      // empty flag set on shifter load, cleared on data write; held set while off or after a master fault
      if (!ctrl.module_on || mf_cond || last_byte)
        stat.tx_empty_flag <= 1'b1;
      else if (push)
        stat.tx_empty_flag <= 1'b0;
      // two-step clears for overrun and mode fault: arm on status read, complete on second step; rx full clears on a data read alone
      if (stat_re && !freeze) begin
        rf_armed <= stat.overrun_flag;
        mf_armed <= stat.mode_fault_flag;
      end
      if (data_re && !freeze)
        stat.rx_full_flag <= 1'b0;
      if (data_re && rf_armed && !freeze) begin
        stat.overrun_flag <= 1'b0;
        rf_armed <= 1'b0;
      end
      if (ctrl_we && mf_armed && !freeze && !mf_cond) begin
        stat.mode_fault_flag <= 1'b0;
        mf_armed <= 1'b0;
      end
      if (active && cap_bit1 && stat.rx_full_flag)
        stat.overrun_flag <= 1'b1;
      if (active && byte_done && !stat.rx_full_flag && !stat.overrun_flag) begin
        rx_data <= {shifter[6:0], ctrl.master_select ? miso_s : mosi_s};
        stat.rx_full_flag <= 1'b1;
      end
      if (mf_cond)
        stat.mode_fault_flag <= 1'b1;
      if (ctrl.module_on && ctrl.fault_detect_en && !ctrl.master_select && ss_n_s && run)
        stat.mode_fault_flag <= 1'b1;
    end
  end
  assign last_byte = buf_pop;

  // interrupt levels, registered; both wake the cpu from wait
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_irq <= 1'b0;
      rx_err_irq <= 1'b0;
    end else begin
      tx_irq <= stat.tx_empty_flag && ctrl.tx_empty_irq_en;
      rx_err_irq <= (stat.rx_full_flag && ctrl.rx_full_irq_en && ctrl.module_on)
                    || (ctrl.error_irq_en
                        && (stat.overrun_flag || stat.mode_fault_flag));
    end
  end

  // pin drive: module owns directions only while on
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_pin <= '0;
      mosi_pin <= '0;
      miso_pin <= '0;
      pins_owned <= 1'b0;
    end else begin
      pins_owned <= ctrl.module_on;
      sck_pin.o <= sck_int ^ ctrl.cpol;
      sck_pin.oe <= ctrl.module_on && ctrl.master_select;
      // wired-or: drive low only, release for high
      mosi_pin.o <= shifter[7];
      mosi_pin.oe <= ctrl.module_on && ctrl.master_select
                     && (!ctrl.wired_or_select || !shifter[7]);
      miso_pin.o <= shifter[7];
      miso_pin.oe <= ctrl.module_on && slave_sel;
    end
  end
endmodule : sib_core

// File: sib_core_monitor.sv
// sib_core_monitor: concurrent checks on the serial irq/buffer/reset block
// assumes: one clock domain, bound to every sib_core instance
`timescale 1ns/1ps
module sib_core_monitor
  import sib_pkg::*;
(
  input wire logic clk,            // bus clock
  input wire logic rst,            // sync reset
  input wire logic ctrl_we,        // ctrl load
  input wire logic data_re,        // data read
  input wire logic break_state,    // break level
  input wire logic break_clear_en, // break clear enable
  input wire logic ss_n_in,        // select pin
  input wire sib_ctrl_t ctrl,      // held control
  input wire sib_stat_t stat,      // flags
  input wire logic tx_irq,         // tx request
  input wire logic rx_err_irq,     // rx/error request
  input wire sib_pin_t sck_pin,    // clock drive
  input wire sib_pin_t miso_pin,   // miso drive
  input wire logic pins_owned      // ddr override
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic tx_src;
  logic rx_src;
  // request sources; irq levels follow them one edge later
  assign tx_src = stat.tx_empty_flag && ctrl.tx_empty_irq_en;
  assign rx_src = (stat.rx_full_flag && ctrl.rx_full_irq_en && ctrl.module_on)
    || (ctrl.error_irq_en && (stat.overrun_flag || stat.mode_fault_flag));
  property p_tx_irq;
    tx_irq == $past(tx_src);
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx request wrong");
  property p_rx_irq;
    rx_err_irq == $past(rx_src);
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx request wrong");
  property p_no_fault;
    !ctrl.fault_detect_en && !ctrl_we && !stat.mode_fault_flag |=> !stat.mode_fault_flag;
  endproperty
  a_no_fault: assert property (p_no_fault) else $error("fault without detect");
  property p_off_empty;
    !ctrl.module_on && !ctrl_we |=> stat.tx_empty_flag;
  endproperty
  a_off_empty: assert property (p_off_empty) else $error("empty not set when off");
  property p_off_pins;
    !ctrl.module_on [*2] |-> !pins_owned && !sck_pin.oe && !miso_pin.oe;
  endproperty
  a_off_pins: assert property (p_off_pins) else $error("pins held when off");
  property p_miso_hiz;
    (ss_n_in || ctrl.master_select) [*5] |-> !miso_pin.oe;
  endproperty
  a_miso_hiz: assert property (p_miso_hiz) else $error("miso driven unselected");
  property p_rx_clear;
    data_re && !break_state |=> !stat.rx_full_flag;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("read left rx full");
  property p_break_hold;
    break_state && !break_clear_en && stat.rx_full_flag |=> stat.rx_full_flag;
  endproperty
  a_break_hold: assert property (p_break_hold) else $error("flag moved in break");
  property p_mf_off;
    $rose(stat.mode_fault_flag) && ctrl.master_select |-> ##[0:2] !ctrl.module_on;
  endproperty
  a_mf_off: assert property (p_mf_off) else $error("fault left module on");
  c_overrun: cover property (stat.overrun_flag);
  c_fault: cover property ($rose(stat.mode_fault_flag));
  c_slave: cover property (miso_pin.oe);
endmodule : sib_core_monitor

bind sib_core sib_core_monitor mon_u (.*);

// File: sib_slave_model.sv
// sib_slave_model: far-side slave, phase 1 polarity 0, echoes last byte
// assumes: sel is high only while the block drives the serial clock
`timescale 1ns/1ps
module sib_slave_model (
  input wire logic sck,  // serial clock from block
  input wire logic mosi, // data from block
  input wire logic sel,  // block owns clock
  output logic miso      // data to block
);
  logic [7:0] shift_q = 8'h3c; // first reply, then echo
  logic bit_q = 1'b0;
  // next bit on leading edge, held through the sampling edge
  always @(posedge sck) if (sel) bit_q <= shift_q[7];
  // capture msb first on trailing edge
  always @(negedge sck) if (sel) shift_q <= {shift_q[6:0], mosi};
  // released line shows inverse, never a stale level
  assign miso = sel ? bit_q : ~bit_q;
endmodule : sib_slave_model

// File: sib_core_bench.sv
// sib_core_bench: directed bench for the serial irq/buffer/reset block
// assumes: 20 MHz clock, echoing slave model, control bits as plain ports
`timescale 1ns/1ps
module sib_core_bench
  import sib_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sib_ctrl_t ctrl_wr = '0;
  logic ctrl_we = 1'b0, data_we = 1'b0, data_re = 1'b0, stat_re = 1'b0;
  logic [7:0] data_wr = 8'h00;
  logic break_state = 1'b0, ss_n_in = 1'b1, sck_tb = 1'b0, mosi_tb = 1'b1;
  logic stop_tb = 1'b0, bce = 1'b0;
  sib_ctrl_t ctrl;
  sib_stat_t stat;
  sib_pin_t sck_pin, mosi_pin, miso_pin;
  logic [7:0] rx_data;
  logic [7:0] sb = 8'hc3;
  logic tx_irq, rx_err_irq, pins_owned, sck_w, mosi_w, miso_w, model_miso;
  int err_count = 0;
  int compares = 0;
  // wire levels from all enables; idle mosi rests at pull-up
  assign sck_w = sck_pin.oe ? sck_pin.o : sck_tb;
  assign mosi_w = mosi_pin.oe ? mosi_pin.o : mosi_tb;
  assign miso_w = miso_pin.oe ? miso_pin.o : model_miso;
  initial begin
    forever #25 clk = ~clk;
  end
  sib_core dut_u (.clk(clk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_we(ctrl_we),
    .data_wr(data_wr), .data_we(data_we), .data_re(data_re), .stat_re(stat_re),
    .stop_mode(stop_tb), .break_state(break_state), .break_clear_en(bce),
    .sck_in(sck_w), .mosi_in(mosi_w), .miso_in(miso_w), .ss_n_in(ss_n_in),
    .ctrl(ctrl), .stat(stat), .rx_data(rx_data), .tx_irq(tx_irq),
    .rx_err_irq(rx_err_irq), .sck_pin(sck_pin), .mosi_pin(mosi_pin),
    .miso_pin(miso_pin), .pins_owned(pins_owned));
  sib_slave_model far_u (.sck(sck_w), .mosi(mosi_w), .sel(sck_pin.oe), .miso(model_miso));
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // each strobe is one cycle wide
  task wr_ctrl(input sib_ctrl_t c);
    @(posedge clk) ctrl_wr <= c;
    ctrl_we <= 1'b1;
    @(posedge clk) ctrl_we <= 1'b0;
  endtask : wr_ctrl
  task wr_data(input logic [7:0] b);
    @(posedge clk) data_wr <= b;
    data_we <= 1'b1;
    @(posedge clk) data_we <= 1'b0;
  endtask : wr_data
  // status read then data read: clears rx full and overrun
  task rd_clear;
    @(posedge clk) stat_re <= 1'b1;
    @(posedge clk) stat_re <= 1'b0;
    data_re <= 1'b1;
    @(posedge clk) data_re <= 1'b0;
  endtask : rd_clear
  // bounded wait on one flag bit: 3 empty, 2 full, 1 overrun, 0 fault
  task wait_bit(input int b);
    int i;
    @(negedge clk);
    for (i = 0; i < 400 && stat[b] !== 1'b1; i++) @(negedge clk);
    if (i == 400) begin
      err_count++;
      $display("mismatch flag %0d expected 1 seen 0", b);
      end_of_test;
    end
  endtask : wait_bit
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk("stat", stat, 4'h8);
    chk("ctrl", ctrl, 11'h280);
    chk("irq pins", {tx_irq, rx_err_irq, pins_owned}, 3'h0);
    $display("test reset done");
    wr_ctrl(11'h6b9);
    tick(4);
    chk("pin oe", {pins_owned, sck_pin.oe, mosi_pin.oe, miso_pin.oe}, 4'he);
    chk("tx irq", tx_irq, 1'b1);
    wr_data(8'ha5);
    wait_bit(2);
    chk("rx byte", rx_data, 8'h3c);
    tick(1);
    chk("rx irq", rx_err_irq, 1'b1);
    rd_clear;
    tick(1);
    chk("rx full", stat.rx_full_flag, 1'b0);
    // two queued bytes, second lands on unread data
    @(posedge clk) data_wr <= 8'h11;
    data_we <= 1'b1;
    @(posedge clk) data_wr <= 8'h22;
    @(posedge clk) data_we <= 1'b0;
    wait_bit(1);
    chk("kept byte", rx_data, 8'ha5);
    tick(1);
    chk("err irq", rx_err_irq, 1'b1);
    $display("test master done");
    @(posedge clk) break_state <= 1'b1;
    rd_clear;
    wr_data(8'h55);
    tick(80);
    chk("break stat", stat, 4'he);
    chk("break rx", rx_data, 8'ha5);
    @(posedge clk) break_state <= 1'b0;
    wr_ctrl(11'h2b9);
    tick(3);
    chk("off stat", stat, 4'he);
    chk("off ctrl", ctrl, 11'h2b9);
    chk("off pins", {pins_owned, sck_pin.oe}, 2'h0);
    rd_clear;
    tick(1);
    chk("cleared", stat, 4'h8);
    $display("test break and off done");
    @(posedge clk) ss_n_in <= 1'b0;
    wr_ctrl(11'h6b9);
    tick(20);
    chk("no fault", stat.mode_fault_flag, 1'b0);
    wr_ctrl(11'h6bd);
    wait_bit(0);
    tick(3);
    chk("fault off", {ctrl.module_on, stat.tx_empty_flag, rx_err_irq}, 3'h3);
    @(posedge clk) ss_n_in <= 1'b1;
    tick(4);
    rd_clear;
    wr_ctrl(11'h4b8);
    tick(2);
    chk("fault clr", stat.mode_fault_flag, 1'b0);
    $display("test fault done");
    // slave byte on a 400 ns link clock, idle between frames
    @(posedge clk) ss_n_in <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk) mosi_tb <= sb[i];
      sck_tb <= 1'b1;
      repeat (4) @(posedge clk);
      sck_tb <= 1'b0;
      repeat (3) @(posedge clk);
    end
    wait_bit(2);
    chk("slave rx", rx_data, 8'hc3);
    chk("miso on", miso_pin.oe, 1'b1);
    @(posedge clk) ss_n_in <= 1'b1;
    tick(6);
    chk("miso off", miso_pin.oe, 1'b0);
    $display("test slave done");
    // stop holds the queued byte; exit starts the master transfer
    wr_ctrl(11'h6b9);
    rd_clear;
    @(posedge clk) stop_tb <= 1'b1;
    wr_data(8'h5a);
    tick(40);
    chk("stop stat", stat, 4'h0);
    @(posedge clk) stop_tb <= 1'b0;
    wait_bit(2);
    chk("stop rx", rx_data, 8'h22);
    // break with clear enable lets a data read clear rx full
    @(posedge clk) break_state <= 1'b1;
    bce <= 1'b1;
    rd_clear;
    tick(1);
    chk("bce clear", stat.rx_full_flag, 1'b0);
    @(posedge clk) break_state <= 1'b0;
    bce <= 1'b0;
    $display("test stop and break clear done");
    end_of_test;
  end
endmodule : sib_core_bench
